// ===== common/ppfm_cfg.svh
// offsets, field positions, reset values and timing figures of the flow measure block
`ifndef PPFM_CFG_SVH
`define PPFM_CFG_SVH

// timing
`define PPFM_CLK_HZ        32'h0098_9680
`define PPFM_MS_PER_S      32'h0000_03E8
`define PPFM_CONFIRM_MS    12'h07D0
`define PPFM_SEC_LAST_MS   10'h03E7
`define PPFM_MGPM_SCALE    64'h0000_0000_0000_EA60

// register byte offsets
`define PPFM_OFS_CTRL      8'h00
`define PPFM_OFS_WINDOW    8'h04
`define PPFM_OFS_CALFACT   8'h08
`define PPFM_OFS_FILTER    8'h0C
`define PPFM_OFS_DENSITY   8'h10
`define PPFM_OFS_LINGAIN   8'h14
`define PPFM_OFS_FSCALE    8'h18
`define PPFM_OFS_CUTOFF    8'h1C
`define PPFM_OFS_HIALARM   8'h20
`define PPFM_OFS_LOALARM   8'h24
`define PPFM_OFS_EVFLAGS   8'h28
`define PPFM_OFS_EVMASK    8'h2C
`define PPFM_OFS_CALCMD    8'h30
`define PPFM_OFS_CALSEC    8'h34
`define PPFM_OFS_FLOW      8'h38
`define PPFM_OFS_RAWCNT    8'h3C
`define PPFM_OFS_RAWPER    8'h40

// field positions
`define PPFM_CTRL_METHOD   0
`define PPFM_CTRL_LINEN    1
`define PPFM_CTRL_MASS     2
`define PPFM_FILT_SMP_LSB  8
`define PPFM_CMD_ARM       0
`define PPFM_CMD_CONFIRM   1

// limits and reset values
`define PPFM_WIN_MIN       16'h01F4
`define PPFM_WIN_MAX       16'hEA60
`define PPFM_WIN_RST       16'h0FA0
`define PPFM_DAMP_MAX      7'h63
`define PPFM_DAMP_RST      7'h05
`define PPFM_SMP_MIN       6'h01
`define PPFM_SMP_MAX       6'h20
`define PPFM_SMP_RST       6'h05
`define PPFM_DENS_MIN      20'h0_03E8
`define PPFM_DENS_MAX      20'h7_A120
`define PPFM_DENS_RST      20'h1_86A0
`define PPFM_DENS_RECIP    16'hA7C6
`define PPFM_LIN_ONE       16'h8000
`define PPFM_CUT_MAX       7'h64
`define PPFM_HYST_PM       8'h0A
`define PPFM_PERMILLE      11'h3E8
`define PPFM_OVR_PCT       8'h7D
`define PPFM_PCT           8'h64
`define PPFM_EV_INT_BITS   16'h030E
`define PPFM_EV_OVR        1
`define PPFM_EV_HI         2
`define PPFM_EV_LO         3
`define PPFM_EV_MAINTOT    8
`define PPFM_EV_PILOTTOT   9

`endif

// ===== common/ppfm_pkg.sv
// types of the flow measure block
package ppfm_pkg;

    typedef enum logic [2:0] {
        S_IDLE     = 3'b000,
        S_DIVF     = 3'b001,
        S_FILT_RD  = 3'b010,
        S_FILT_SUM = 3'b011,
        S_DIVA     = 3'b100,
        S_POST     = 3'b101
    } ppfm_seq_e;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } ppfm_apb_req_s;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } ppfm_apb_rsp_s;

    typedef struct packed {
        ppfm_seq_e     seq;
        logic [1:0]    pinSync;
        logic          pinLast;
        logic [31:0]   period;
        logic          edgeSeen;
        logic [15:0]   msDiv;
        logic [15:0]   winCnt;
        logic [31:0]   pulseCnt;
        logic [31:0]   rawCount;
        logic [31:0]   rawPeriod;
        logic          method;
        logic          linEn;
        logic          mass;
        logic [15:0]   winSet;
        logic [15:0]   calFactor;
        logic [6:0]    damping;
        logic [5:0]    samples;
        logic [19:0]   density;
        logic [15:0]   linGain;
        logic [31:0]   fullScale;
        logic [6:0]    cutoff;
        logic [31:0]   hiAlarm;
        logic [31:0]   loAlarm;
        logic [15:0]   evFlags;
        logic [15:0]   evMask;
        logic          armed;
        logic [11:0]   armMs;
        logic [9:0]    secMs;
        logic [31:0]   calSec;
        logic [63:0]   divNum;
        logic [63:0]   divDen;
        logic [63:0]   divRem;
        logic [6:0]    divCnt;
        logic [31:0]   sample;
        logic [5:0]    fill;
        logic [4:0]    ptr;
        logic [36:0]   sum;
        logic [31:0]   avgOut;
        logic          cutActive;
        logic [31:0]   flow;
        logic          strobe;
        ppfm_apb_rsp_s rsp;
    } ppfm_state_s;

endpackage

// ===== design/ppfm_sample_mem.sv
// sample memory of the running average, registered read
`timescale 1ns/1ps
module ppfm_sample_mem #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 32,
    parameter int unsigned AW    = $clog2(DEPTH)
) (
    input  wire logic             clk,
    input  wire logic             wrEn,
    input  wire logic [AW-1:0]    wrAddr,
    input  wire logic [WIDTH-1:0] wrData,
    input  wire logic [AW-1:0]    rdAddr,
    output logic      [WIDTH-1:0] rdData
);
    logic [WIDTH-1:0] mem [DEPTH];

    // contents need no reset, fill count tells valid slots
    always_ff @(posedge clk) begin
        if (wrEn) mem[wrAddr] <= wrData;
        rdData <= mem[rdAddr];
    end
endmodule // ppfm_sample_mem

// ===== design/ppfm_top.sv
// paddle wheel pulse flow measurement with apb registers
// How it works
// RULE1: window count or pulse width, selectable
// RULE2: window 500..60000 ms, others rejected
// RULE3: window only drives the count method
// RULE4: frequency divided by pulses per gallon
// RULE5: reset selects pulse width timing
// RULE6: filter bypassed in count mode
// RULE7: filter is a running average
// RULE8: damping 0..99, default 5, zero disables
// RULE9: sample count 1..32 sets average depth
// RULE10: software should start with five samples
// RULE11: software should use windows above 4000 ms
// RULE12: linearizer on both methods, on at reset
// RULE13: mass units scale by density 0.01..5
// RULE14: calibration timer counts operating time
// RULE15: timer clear needs confirm within 2 s
// RULE16: sixteen event bits, bit 15 fatal
// RULE17: bit 1 set above 125 percent scale
// RULE18: bits 2,3 alarms; 8,9 totalizer events
// RULE19: event bits stay until cleared
// RULE20: event bits clear at power up
// RULE21: masked events never set their bit
// RULE22: cut-off forces zero, 1.0 percent hysteresis
// RULE23: width mode times clock cycles per period
// RULE24: sensor input passes two flip-flops first
`timescale 1ns/1ps
`include "ppfm_cfg.svh"
module ppfm_top #(
    parameter int unsigned  MS_CYCLES = `PPFM_CLK_HZ / `PPFM_MS_PER_S,
    parameter logic [15:0]  CAL_RST   = 16'h03E8
) (
    input  wire logic                   sys_clk,
    input  wire logic                   reset,
    input  wire ppfm_pkg::ppfm_apb_req_s apbReq,
    output ppfm_pkg::ppfm_apb_rsp_s      apbRsp,
    input  wire logic                   sensorPulse,
    input  wire logic [15:0]            extEvents,
    input  wire logic                   mainTotEvent,
    input  wire logic                   pilotTotEvent,
    input  wire logic                   keypadClear,
    output logic      [31:0]            flowRate,
    output logic                        flowStrobe,
    output logic      [15:0]            eventFlags
);
    ppfm_pkg::ppfm_state_s q;
    ppfm_pkg::ppfm_state_s d;

    logic        riseEdge;
    logic        msTick;
    logic        secWrap;
    logic        startReq;
    logic [31:0] startN;
    logic [31:0] startT;
    logic [63:0] shifted;
    logic        borrow;
    logic [31:0] quot;
    logic [47:0] linProd;
    logic [31:0] linVal;
    logic [33:0] diff;
    logic [47:0] flowPm;
    logic [47:0] cutThr;
    logic [47:0] hystThr;
    logic [67:0] massProd;
    logic [31:0] outVal;
    logic        setup;
    logic        commit;
    logic [15:0] evSet;
    logic [15:0] evClr;
    logic        memWr;
    logic [4:0]  rdAddr;
    logic [31:0] rdData;

    // address decode shared by read and write paths
    function automatic logic regKnown(input logic [7:0] a);
        regKnown = (a[1:0] == 2'b00) && (a <= `PPFM_OFS_RAWPER);
    endfunction

    // damping setting to shift of the second smoothing stage
    function automatic logic [2:0] dampShift(input logic [6:0] t);
        dampShift = 3'h0;
        for (int i = 0; i < 7; i++) begin
            if (t[i]) dampShift = 3'(i + 1);
        end
    endfunction

    ppfm_sample_mem #(
        .WIDTH (32),
        .DEPTH (32)
    ) u_mem (
        .clk    (sys_clk),
        .wrEn   (memWr),
        .wrAddr (q.ptr),
        .wrData (q.sample),
        .rdAddr (rdAddr),
        .rdData (rdData)
    );

    // oldest sample of the window leaves when a new one enters
    assign rdAddr = q.ptr - q.samples[4:0]; // RULE9

    always_comb begin
        d = q;
        d.strobe = 1'b0;
        d.rsp = '0;
        startReq = 1'b0;
        startN = 32'h0000_0000;
        startT = 32'h0000_0001;
        memWr = 1'b0;
        evSet = 16'h0000;
        evClr = 16'h0000;
        {flowPm, cutThr, hystThr, massProd} = '0;

        // sensor pin synchroniser and edge detect
        d.pinSync = {q.pinSync[0], sensorPulse}; // RULE24
        d.pinLast = q.pinSync[1];
        riseEdge = q.pinSync[1] & ~q.pinLast; // RULE24

        // millisecond enable
        msTick = (q.msDiv == 16'(MS_CYCLES - 1));
        d.msDiv = msTick ? 16'h0000 : q.msDiv + 16'h0001;

        // operating time keeps running from reset on
        secWrap = msTick && (q.secMs == `PPFM_SEC_LAST_MS);
        if (msTick) d.secMs = secWrap ? 10'h000 : q.secMs + 10'h001;
        if (secWrap) d.calSec = q.calSec + 32'h0000_0001; // RULE14

        // confirm window closes after the set time
        if (q.armed && msTick) begin
            d.armMs = q.armMs + 12'h001;
            if (q.armMs == `PPFM_CONFIRM_MS - 12'h001) begin
                d.armed = 1'b0; // RULE15
            end
        end

        // width timer saturates so a stalled wheel reads as no flow
        d.period = (q.period == 32'hFFFF_FFFF) ? q.period : q.period + 32'h0000_0001;
        if (q.method && q.period == 32'hFFFF_FFFF) d.flow = 32'h0000_0000;

        // pulse width: cycles between rising edges
        if (riseEdge) begin
            d.period = 32'h0000_0001;
            d.edgeSeen = 1'b1;
            if (q.method && q.edgeSeen) begin // RULE1
                d.rawPeriod = q.period; // RULE23
                startReq = 1'b1;
                startN = 32'h0000_0001;
                startT = q.period; // RULE23
            end
        end

        // pulse count over the programmed window
        if (!q.method) begin
            d.pulseCnt = q.pulseCnt + {31'h0, riseEdge};
            if (msTick) begin
                d.winCnt = q.winCnt + 16'h0001;
                if (q.winCnt + 16'h0001 >= q.winSet) begin // RULE3
                    d.winCnt = 16'h0000;
                    d.pulseCnt = 32'h0000_0000;
                    d.rawCount = q.pulseCnt + {31'h0, riseEdge};
                    startReq = 1'b1; // RULE1
                    startN = q.pulseCnt + {31'h0, riseEdge};
                    startT = 32'(q.winSet) * 32'(MS_CYCLES); // RULE3
                end
            end
        end

        // shared restoring divider, one quotient bit a cycle
        shifted = {q.divRem[62:0], q.divNum[63]};
        borrow = shifted < q.divDen;
        if (q.seq == ppfm_pkg::S_DIVF || q.seq == ppfm_pkg::S_DIVA) begin
            d.divRem = borrow ? shifted : shifted - q.divDen;
            d.divNum = {q.divNum[62:0], ~borrow};
            d.divCnt = q.divCnt + 7'h01;
        end
        quot = (|d.divNum[63:32]) ? 32'hFFFF_FFFF : d.divNum[31:0];

        // correction gain, 0x8000 is unity
        linProd = 48'(quot) * 48'(q.linGain);
        linVal = linProd[47] ? 32'hFFFF_FFFF : linProd[46:15];

        // second stage makes a longer damping respond slower
        diff = {2'b00, quot} - {2'b00, q.avgOut};
        outVal = q.sample;

        case (q.seq)
            ppfm_pkg::S_IDLE: begin
                // a result still in work drops the newer sample
                if (startReq) begin
                    d.divNum = 64'(startN) * (64'(`PPFM_CLK_HZ) * `PPFM_MGPM_SCALE); // RULE4
                    d.divDen = 64'(startT) * 64'(q.calFactor); // RULE4
                    d.divRem = 64'h0;
                    d.divCnt = 7'h00;
                    d.seq = ppfm_pkg::S_DIVF;
                end
            end
            ppfm_pkg::S_DIVF: begin
                if (q.divCnt == 7'h3F) begin
                    d.sample = q.linEn ? linVal : quot; // RULE12
                    if (q.method && q.damping != 7'h00) begin // RULE6
                        d.seq = ppfm_pkg::S_FILT_RD;
                    end else begin
                        d.seq = ppfm_pkg::S_POST; // RULE8
                    end
                end
            end
            ppfm_pkg::S_FILT_RD: begin
                d.seq = ppfm_pkg::S_FILT_SUM;
            end
            ppfm_pkg::S_FILT_SUM: begin
                memWr = 1'b1;
                d.ptr = q.ptr + 5'h01;
                if (q.fill < q.samples) begin
                    d.fill = q.fill + 6'h01;
                    d.sum = q.sum + 37'(q.sample);
                end else begin
                    d.sum = q.sum + 37'(q.sample) - 37'(rdData); // RULE7
                end
                d.divNum = 64'(d.sum);
                d.divDen = 64'(d.fill);
                d.divRem = 64'h0;
                d.divCnt = 7'h00;
                d.seq = ppfm_pkg::S_DIVA;
            end
            ppfm_pkg::S_DIVA: begin
                if (q.divCnt == 7'h3F) begin
                    d.avgOut = 32'(34'(q.avgOut) + 34'($signed(diff) >>> dampShift(q.damping))); // RULE8
                    d.sample = d.avgOut; // RULE7
                    d.seq = ppfm_pkg::S_POST;
                end
            end
            ppfm_pkg::S_POST: begin
                // cut-off with hysteresis, compared in permille of scale
                flowPm = 48'(q.sample) * 48'(`PPFM_PERMILLE);
                cutThr = 48'(q.cutoff) * 48'(q.fullScale);
                hystThr = 48'(8'(q.cutoff) + `PPFM_HYST_PM) * 48'(q.fullScale);
                d.cutActive = flowPm < (q.cutActive ? hystThr : cutThr); // RULE22
                outVal = d.cutActive ? 32'h0000_0000 : q.sample; // RULE22
                // alarms on the volumetric rate
                evSet[`PPFM_EV_OVR] = 48'(q.sample) * 48'(`PPFM_PCT) >
                                      48'(q.fullScale) * 48'(`PPFM_OVR_PCT); // RULE17
                evSet[`PPFM_EV_HI] = (q.hiAlarm != 32'h0) && (q.sample > q.hiAlarm); // RULE18
                evSet[`PPFM_EV_LO] = q.sample < q.loAlarm; // RULE18
                // density scaled by a reciprocal, error below 1e-4
                massProd = 68'(outVal) * 68'(q.density) * 68'(`PPFM_DENS_RECIP);
                if (q.mass) begin
                    outVal = (|massProd[67:64]) ? 32'hFFFF_FFFF : massProd[63:32]; // RULE13
                end
                d.flow = outVal;
                d.strobe = 1'b1;
                d.seq = ppfm_pkg::S_IDLE;
            end
            default: begin
                d.seq = ppfm_pkg::S_IDLE;
            end
        endcase

        // apb: answer in the first access cycle
        setup = apbReq.psel & ~apbReq.penable;
        commit = apbReq.psel & apbReq.penable & q.rsp.pready;
        d.rsp.pready = setup;
        d.rsp.pslverr = setup & ~regKnown(apbReq.paddr);
        if (setup && !apbReq.pwrite) begin
            case (apbReq.paddr)
                `PPFM_OFS_CTRL:    d.rsp.prdata = {29'h0, q.mass, q.linEn, q.method};
                `PPFM_OFS_WINDOW:  d.rsp.prdata = {16'h0, q.winSet};
                `PPFM_OFS_CALFACT: d.rsp.prdata = {16'h0, q.calFactor};
                `PPFM_OFS_FILTER:  d.rsp.prdata = {18'h0, q.samples, 1'b0, q.damping};
                `PPFM_OFS_DENSITY: d.rsp.prdata = {12'h0, q.density};
                `PPFM_OFS_LINGAIN: d.rsp.prdata = {16'h0, q.linGain};
                `PPFM_OFS_FSCALE:  d.rsp.prdata = q.fullScale;
                `PPFM_OFS_CUTOFF:  d.rsp.prdata = {25'h0, q.cutoff};
                `PPFM_OFS_HIALARM: d.rsp.prdata = q.hiAlarm;
                `PPFM_OFS_LOALARM: d.rsp.prdata = q.loAlarm;
                `PPFM_OFS_EVFLAGS: d.rsp.prdata = {16'h0, q.evFlags};
                `PPFM_OFS_EVMASK:  d.rsp.prdata = {16'h0, q.evMask};
                `PPFM_OFS_CALCMD:  d.rsp.prdata = {31'h0, q.armed};
                `PPFM_OFS_CALSEC:  d.rsp.prdata = q.calSec;
                `PPFM_OFS_FLOW:    d.rsp.prdata = q.flow;
                `PPFM_OFS_RAWCNT:  d.rsp.prdata = q.rawCount;
                `PPFM_OFS_RAWPER:  d.rsp.prdata = q.rawPeriod;
                default: ;
            endcase
        end

        // register writes; out of range values keep the old setting
        if (commit && apbReq.pwrite) begin
            case (apbReq.paddr)
                `PPFM_OFS_CTRL: begin
                    d.method = apbReq.pwdata[`PPFM_CTRL_METHOD]; // RULE1
                    d.linEn = apbReq.pwdata[`PPFM_CTRL_LINEN];
                    d.mass = apbReq.pwdata[`PPFM_CTRL_MASS];
                    d.winCnt = 16'h0000;
                    d.pulseCnt = 32'h0000_0000;
                end
                `PPFM_OFS_WINDOW: begin
                    if (apbReq.pwdata[31:16] == 16'h0 && apbReq.pwdata[15:0] >= `PPFM_WIN_MIN &&
                        apbReq.pwdata[15:0] <= `PPFM_WIN_MAX) begin
                        d.winSet = apbReq.pwdata[15:0]; // RULE2
                    end
                end
                `PPFM_OFS_CALFACT: begin
                    if (apbReq.pwdata[15:0] != 16'h0) d.calFactor = apbReq.pwdata[15:0];
                end
                `PPFM_OFS_FILTER: begin
                    if (apbReq.pwdata[6:0] <= `PPFM_DAMP_MAX) d.damping = apbReq.pwdata[6:0]; // RULE8
                    if (apbReq.pwdata[13:8] >= `PPFM_SMP_MIN && apbReq.pwdata[13:8] <= `PPFM_SMP_MAX) begin
                        d.samples = apbReq.pwdata[`PPFM_FILT_SMP_LSB +: 6]; // RULE9
                    end
                    // depth change restarts the average to keep the sum honest
                    d.fill = 6'h00;
                    d.sum = 37'h0;
                end
                `PPFM_OFS_DENSITY: begin
                    if (apbReq.pwdata[31:20] == 12'h0 && apbReq.pwdata[19:0] >= `PPFM_DENS_MIN &&
                        apbReq.pwdata[19:0] <= `PPFM_DENS_MAX) begin
                        d.density = apbReq.pwdata[19:0]; // RULE13
                    end
                end
                `PPFM_OFS_LINGAIN: d.linGain = apbReq.pwdata[15:0];
                `PPFM_OFS_FSCALE:  d.fullScale = apbReq.pwdata;
                `PPFM_OFS_CUTOFF: begin
                    if (apbReq.pwdata[6:0] <= `PPFM_CUT_MAX) d.cutoff = apbReq.pwdata[6:0];
                end
                `PPFM_OFS_HIALARM: d.hiAlarm = apbReq.pwdata;
                `PPFM_OFS_LOALARM: d.loAlarm = apbReq.pwdata;
                `PPFM_OFS_EVFLAGS: evClr = apbReq.pwdata[15:0]; // RULE19
                `PPFM_OFS_EVMASK:  d.evMask = apbReq.pwdata[15:0];
                `PPFM_OFS_CALCMD: begin
                    if (apbReq.pwdata[`PPFM_CMD_CONFIRM] && q.armed) begin
                        d.calSec = 32'h0000_0000; // RULE15
                        d.secMs = 10'h000;
                        d.armed = 1'b0;
                    end else if (apbReq.pwdata[`PPFM_CMD_ARM]) begin
                        d.armed = 1'b1; // RULE15
                        d.armMs = 12'h000;
                    end
                end
                default: ;
            endcase
        end

        // sticky events, set beats clear, masked ones never land
        if (keypadClear) evClr = 16'hFFFF; // RULE19
        evSet = evSet | (extEvents & ~`PPFM_EV_INT_BITS); // RULE16
        evSet[`PPFM_EV_MAINTOT] = mainTotEvent; // RULE18
        evSet[`PPFM_EV_PILOTTOT] = pilotTotEvent; // RULE18
        d.evFlags = (q.evFlags & ~evClr) | (evSet & ~q.evMask); // RULE21
    end

    // state register; reset stands for power up
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            q <= '0;
            q.method <= 1'b1; // RULE5
            q.linEn <= 1'b1; // RULE12
            q.winSet <= `PPFM_WIN_RST;
            q.calFactor <= CAL_RST;
            q.damping <= `PPFM_DAMP_RST; // RULE8
            q.samples <= `PPFM_SMP_RST;
            q.density <= `PPFM_DENS_RST;
            q.linGain <= `PPFM_LIN_ONE;
            q.fullScale <= 32'hFFFF_FFFF;
            q.evFlags <= 16'h0000; // RULE20
        end else begin
            q <= d;
        end
    end

    assign apbRsp = q.rsp;
    assign flowRate = q.flow;
    assign flowStrobe = q.strobe;
    assign eventFlags = q.evFlags;
endmodule // ppfm_top

// ===== verif/ppfm_properties.sv
// port assertions of the flow measure block
`timescale 1ns/1ps
`include "ppfm_cfg.svh"
module ppfm_checker (
    input wire logic                    sys_clk,
    input wire logic                    reset,
    input wire ppfm_pkg::ppfm_apb_req_s apbReq,
    input wire ppfm_pkg::ppfm_apb_rsp_s apbRsp,
    input wire logic [15:0]             extEvents,
    input wire logic                    mainTotEvent,
    input wire logic                    keypadClear,
    input wire logic [31:0]             flowRate,
    input wire logic                    flowStrobe,
    input wire logic [15:0]             eventFlags
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // wide on purpose: any write cycle to the flag register, setup or access, may clear
    logic clr;
    assign clr = keypadClear | (apbReq.psel & apbReq.pwrite & (apbReq.paddr == `PPFM_OFS_EVFLAGS));
    sequence s_setup;
        apbReq.psel && !apbReq.penable;
    endsequence
    a_ready_next: assert property (s_setup |=> apbRsp.pready) else $error("no ready");
    a_ready_once: assert property (apbRsp.pready |=> !apbRsp.pready) else $error("long ready");
    a_flags_power: assert property ($fell(reset) |-> eventFlags == 16'h0000) else $error("flags set");
    a_flags_sticky: assert property (!$past(clr) && !$past(clr, 2) && !$past(clr, 3) |->
        (eventFlags & $past(eventFlags)) == $past(eventFlags)) else $error("flag dropped");
    a_fatal_set: assert property (extEvents[15] |-> ##[1:3] eventFlags[15]) else $error("no bit 15");
    a_total_set: assert property (mainTotEvent |-> ##[1:3] eventFlags[8]) else $error("no bit 8");
    a_strobe_once: assert property (flowStrobe |=> !flowStrobe [*8]) else $error("long strobe");
    a_rate_hold: assert property ($changed(flowRate) |-> flowStrobe) else $error("rate moved");
endmodule // ppfm_checker
bind ppfm_top ppfm_checker u_chk (.sys_clk, .reset, .apbReq, .apbRsp, .extEvents, .mainTotEvent, .keypadClear,
    .flowRate, .flowStrobe, .eventFlags);

// ===== verif/ppfm_sensor_model.sv
// paddle wheel sensor: square wave of a set half period
`timescale 1ns/1ps
module ppfm_sensor_model (
    input wire logic        sys_clk,
    input wire logic [15:0] halfCycles,
    output logic            pulse
);
    logic [15:0] cnt = 16'h0000;
    initial pulse = 1'b0;
    // free running wheel; pin toggles every half period
    always @(posedge sys_clk) begin
        cnt <= (cnt + 16'h0001 >= halfCycles) ? 16'h0000 : cnt + 16'h0001;
        if (cnt + 16'h0001 >= halfCycles) pulse <= ~pulse;
    end
endmodule // ppfm_sensor_model

// ===== verif/ppfm_tb_top.sv
// self checking bench of the flow measure block
`timescale 1ns/1ps
`include "ppfm_cfg.svh"
module ppfm_tb_top;
    logic                    sys_clk, reset, pin, mainTot, pilotTot, kpClr, flowStrobe, er;
    ppfm_pkg::ppfm_apb_req_s req;
    ppfm_pkg::ppfm_apb_rsp_s rsp;
    logic [15:0]             ext, eventFlags;
    logic [31:0]             flowRate, rd;
    int                      errCount, checkCount;
    // entries: offset, written value, value read back
    logic [71:0] tbl [9] = '{72'h04_0000_01F3_0000_0FA0, 72'h04_0000_01F4_0000_01F4, 72'h04_0000_EA61_0000_01F4,
        72'h04_0000_EA60_0000_EA60, 72'h0C_0000_2163_0000_0563, 72'h0C_0000_2063_0000_2063,
        72'h0C_0000_0064_0000_2063, 72'h10_0000_03E7_0001_86A0, 72'h10_0007_A120_0007_A120};
    // short ms tick keeps the timer and window scenarios brief
    ppfm_top #(.MS_CYCLES(10), .CAL_RST(16'h03E8)) dut (.sys_clk, .reset, .apbReq(req), .apbRsp(rsp),
        .sensorPulse(pin), .extEvents(ext), .mainTotEvent(mainTot), .pilotTotEvent(pilotTot),
        .keypadClear(kpClr), .flowRate, .flowStrobe, .eventFlags);
    ppfm_sensor_model u_sensor (.sys_clk, .halfCycles(16'h0064), .pulse(pin));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            errCount++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; request held until ready is seen
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        do @(posedge sys_clk); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask
    task automatic strobes(input int k);
        repeat (k) do @(posedge sys_clk); while (flowStrobe !== 1'b1);
    endtask
    task automatic t_regs();
        rdc(`PPFM_OFS_CTRL, 32'h0000_0003);
        rdc(`PPFM_OFS_FILTER, 32'h0000_0505);
        foreach (tbl[i]) begin
            apb(1'b1, tbl[i][71:64], tbl[i][63:32]);
            rdc(tbl[i][71:64], tbl[i][31:0]);
        end
        apb(1'b0, 8'h44, 32'h0000_0000);
        check({31'h0, er}, 32'h0000_0001);
    endtask
    task automatic t_events();
        apb(1'b1, `PPFM_OFS_EVMASK, 32'h0000_4000);
        ext <= 16'hC000;
        mainTot <= 1'b1;
        pilotTot <= 1'b1;
        @(posedge sys_clk);
        {ext, mainTot, pilotTot} <= 18'h0_0000;
        repeat (3) @(posedge sys_clk);
        check({16'h0000, eventFlags}, 32'h0000_8300);
        apb(1'b1, `PPFM_OFS_EVFLAGS, 32'h0000_0300);
        rdc(`PPFM_OFS_EVFLAGS, 32'h0000_8000);
    endtask
    task automatic t_flow();
        apb(1'b1, `PPFM_OFS_WINDOW, 32'h0000_01F4);
        apb(1'b1, `PPFM_OFS_FILTER, 32'h0000_0505);
        apb(1'b1, `PPFM_OFS_CTRL, 32'h0000_0002);
        strobes(3);
        check(flowRate, 32'h002D_C6C0);
        apb(1'b1, `PPFM_OFS_FILTER, 32'h0000_0100);
        apb(1'b1, `PPFM_OFS_CTRL, 32'h0000_0003);
        strobes(2);
        check(flowRate, 32'h002D_C6C0);
        apb(1'b1, `PPFM_OFS_FSCALE, 32'h001E_8480);
        apb(1'b1, `PPFM_OFS_HIALARM, 32'h000F_4240);
        apb(1'b1, `PPFM_OFS_LOALARM, 32'h003D_0900);
        strobes(2);
        rdc(`PPFM_OFS_EVFLAGS, 32'h0000_800E);
        apb(1'b1, `PPFM_OFS_LINGAIN, 32'h0000_4000);
        apb(1'b1, `PPFM_OFS_HIALARM, 32'h0000_0000);
        apb(1'b1, `PPFM_OFS_LOALARM, 32'h0000_0000);
        strobes(2);
        check(flowRate, 32'h0016_E360);
        kpClr <= 1'b1;
        @(posedge sys_clk);
        kpClr <= 1'b0;
        rdc(`PPFM_OFS_EVFLAGS, 32'h0000_0000);
    endtask
    task automatic t_cal();
        logic [31:0] v0;
        apb(1'b0, `PPFM_OFS_CALSEC, 32'h0000_0000);
        v0 = rd;
        repeat (19997) @(posedge sys_clk); // bus overhead makes the gap exactly 2 s
        rdc(`PPFM_OFS_CALSEC, v0 + 32'h0000_0002);
        apb(1'b1, `PPFM_OFS_CALCMD, 32'h0000_0001);
        repeat (21000) @(posedge sys_clk);
        apb(1'b1, `PPFM_OFS_CALCMD, 32'h0000_0002);
        apb(1'b0, `PPFM_OFS_CALSEC, 32'h0000_0000);
        check({31'h0, rd != 32'h0000_0000}, 32'h0000_0001);
        apb(1'b1, `PPFM_OFS_CALCMD, 32'h0000_0001);
        rdc(`PPFM_OFS_CALCMD, 32'h0000_0001);
        apb(1'b1, `PPFM_OFS_CALCMD, 32'h0000_0002);
        rdc(`PPFM_OFS_CALSEC, 32'h0000_0000);
    endtask
    task automatic finish_test();
        $display("Checks %0d, errors %0d", checkCount, errCount);
        if (errCount == 0 && checkCount > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // main sequence
    initial begin
        {reset, req, ext, mainTot, pilotTot, kpClr} = {1'b1, 62'h0};
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        t_regs();
        t_events();
        t_flow();
        t_cal();
        finish_test();
    end
    // watchdog well above the expected 58k cycles
    initial begin
        repeat (90000) @(posedge sys_clk);
        errCount++;
        $display("Error %0t: watchdog expired", $time);
        finish_test();
    end
endmodule // ppfm_tb_top
